// ---- rtl/sbm_top.sv ----
// Purpose: baud selection, timer 1 baud source and mode 0 shift engine
// Assumes: sys_clk is the cpu clock; apb slave with zero wait states
// Notes: async frame logic lives elsewhere and uses the tick outputs
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module sbm_top (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire sbm_pkg::sbm_apb_req_s apb_req,
  output logic                      apb_pready,
  output logic                      apb_pslverr,
  output logic [31:0]               apb_prdata,
  input  wire logic                 timer_count_pin,
  input  wire logic                 shift_data_pin_in,
  output logic                      shift_data_pin_out,
  output logic                      shift_data_pin_oe_n,
  output logic                      shift_clock_pin,
  output logic                      baud_bit_tick,
  output logic                      baud_sample_tick,
  output logic [1:0]                serial_mode
);
  import sbm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  sbm_state_s s_q;
  sbm_state_s s_d;

  logic        setup;
  logic        access;
  logic        wr;
  logic        ovf;
  logic        ev;
  logic        dbl;
  logic        cnt_en;
  logic [13:0] t13;
  logic [16:0] t16;
  logic [1:0]  mode;
  logic [7:0]  rd;
  logic        hit;
  logic [7:0]  rx_word;

  // first bit in ends at the top, so reverse for lsb first
  for (genvar gi = 0; gi < 8; gi++) begin : g_rx_rev
    if (gi == 7) begin : g_last
      assign rx_word[gi] = s_q.samp;
    end else begin : g_mid
      assign rx_word[gi] = s_q.rsr[6 - gi];
    end
  end

  always_comb begin
    s_d      = s_q;
    ovf      = 1'b0;
    ev       = 1'b0;
    t13      = 14'h0;
    t16      = 17'h0;
    rd       = 8'h00;
    hit      = 1'b1;
    setup    = apb_req.psel & ~apb_req.penable;
    access   = apb_req.psel & apb_req.penable;
    wr       = access & apb_req.pwrite;
    mode     = {s_q.ctrl[SBM_CTRL_MODE_HI], s_q.ctrl[SBM_CTRL_MODE_LO]};
    dbl      = s_q.pwr[SBM_PWR_DBL];

    // machine cycle sequencer, six cpu clocks per cycle
    s_d.phase = (s_q.phase == SBM_S6) ? SBM_S1 : 3'(s_q.phase + 3'h1);

    // pin synchronisers
    s_d.t1_sync  = {s_q.t1_sync[0], timer_count_pin};
    s_d.din_sync = {s_q.din_sync[0], shift_data_pin_in};
    s_d.t1_prev  = s_q.t1_sync[1];

    //////////////////////////////////////////////////////////////////////////
    // timer 1: counts machine cycles or pin edges in modes 0 to 2, holds in mode 3
    cnt_en = s_q.timer_mode_reg[SBM_TIMER_MODE_REG_CT] ? (s_q.t1_sync[1] & ~s_q.t1_prev)
                                   : (s_q.phase == SBM_S6);
    if (cnt_en) begin
      case ({s_q.timer_mode_reg[SBM_TIMER_MODE_REG_M1], s_q.timer_mode_reg[SBM_TIMER_MODE_REG_M0]})
        2'b00: begin
          t13      = {1'b0, s_q.th, s_q.tl[4:0]} + 14'h1;
          s_d.th   = t13[12:5];
          s_d.tl   = {s_q.tl[7:5], t13[4:0]};
          ovf      = t13[13];
        end
        2'b01: begin
          t16      = {1'b0, s_q.th, s_q.tl} + 17'h1;
          s_d.th   = t16[15:8];
          s_d.tl   = t16[7:0];
          ovf      = t16[16];
        end
        2'b10: begin
          // auto-reload: period is 256 - reload counts (machine cycles, or pin edges when CT is set)
          if (s_q.tl == 8'hff) begin
            s_d.tl = s_q.th;
            ovf    = 1'b1;
          end else begin
            s_d.tl = 8'(s_q.tl + 8'h1);
          end
        end
        default: begin
          ovf = 1'b0;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // baud divider; 16x ticks feed the async frame logic
    case (mode)
      SBM_SMODE_FIX9: ev = 1'b1;
      SBM_SMODE_ASY8: ev = ovf;
      SBM_SMODE_VAR9: ev = ovf;
      default:        ev = 1'b0;
    endcase
    s_d.bd        = ev ? 5'(s_q.bd + 5'h1) : s_q.bd;
    s_d.samp_tick = ev & (dbl | s_q.bd[0]);
    s_d.bit_tick  = ev & (dbl ? (s_q.bd[3:0] == SBM_BD_LAST16)
                              : (s_q.bd == SBM_BD_LAST32));

    //////////////////////////////////////////////////////////////////////////
    // apb read data and error, captured in the setup cycle
    case (apb_req.paddr)
      SBM_OFS_CTRL:   rd = s_q.ctrl;
      SBM_OFS_BUF:    rd = s_q.rx_buf;
      SBM_OFS_PWR:    rd = s_q.pwr;
      SBM_OFS_TIMER_MODE_REG:   rd = s_q.timer_mode_reg;
      SBM_OFS_RELOAD: rd = s_q.th;
      SBM_OFS_STATUS: rd = {4'h0, (s_q.rx == SBM_RX_ACT),
                            (s_q.tx == SBM_TX_SEND), mode};
      default: begin
        rd  = 8'h00;
        hit = 1'b0;
      end
    endcase
    if (setup) begin
      s_d.prdata  = {24'h0, rd};
      s_d.pslverr = ~hit;
    end

    // software writes; hardware sets below win over a clear
    if (wr) begin
      case (apb_req.paddr)
        SBM_OFS_CTRL:   s_d.ctrl = apb_req.pwdata[7:0];
        SBM_OFS_PWR:    s_d.pwr  = apb_req.pwdata[7:0];
        SBM_OFS_TIMER_MODE_REG:   s_d.timer_mode_reg = apb_req.pwdata[7:0];
        SBM_OFS_RELOAD: s_d.th   = apb_req.pwdata[7:0];
        SBM_OFS_BUF: begin
          if (mode == SBM_SMODE_SHIFT) begin
            s_d.tsr = SBM_TX_MARK | {1'b0, apb_req.pwdata[7:0]};
            s_d.tx  = SBM_TX_PEND;
          end
        end
        default: begin
          s_d.ctrl = s_d.ctrl;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // mode 0 transmit: the write counts as made at state 6 phase 2
    if (s_q.phase == SBM_S6) begin
      case (s_q.tx)
        SBM_TX_PEND: if (s_d.tx == SBM_TX_PEND) s_d.tx = SBM_TX_ARM;
        SBM_TX_ARM:  if (s_d.tx == SBM_TX_ARM) s_d.tx = SBM_TX_SEND;
        SBM_TX_SEND: begin
          if (s_d.tx == SBM_TX_SEND) begin
            s_d.tsr = {1'b0, s_q.tsr[8:1]};
            if (s_q.tsr[8:1] == SBM_TX_LAST) begin
              s_d.tx               = SBM_TX_IDLE;
              s_d.ctrl[SBM_CTRL_TI] = 1'b1;
            end
          end
        end
        default: s_d.tx = s_d.tx;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // mode 0 receive
    case (s_q.rx)
      SBM_RX_IDLE: begin
        if (s_q.phase == SBM_S6 && mode == SBM_SMODE_SHIFT &&
            s_q.ctrl[SBM_CTRL_REN] && !s_q.ctrl[SBM_CTRL_RI]) begin
          s_d.rx = SBM_RX_ARM;
        end
      end
      SBM_RX_ARM: begin
        if (s_q.phase == SBM_S6) begin
          s_d.rsr = SBM_RX_INIT;
          s_d.rx  = SBM_RX_ACT;
        end
      end
      SBM_RX_ACT: begin
        if (s_q.phase == SBM_S5) begin
          s_d.samp = s_q.din_sync[1];
        end
        if (s_q.phase == SBM_S6) begin
          s_d.rsr = {s_q.rsr[6:0], s_q.samp};
          if (!s_q.rsr[7]) begin
            s_d.rx_buf            = rx_word;
            s_d.ctrl[SBM_CTRL_RI] = 1'b1;
            s_d.rx                = SBM_RX_IDLE;
          end
        end
      end
      default: s_d.rx = SBM_RX_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // pins, registered from next state so they align with the phase
    if (s_d.tx == SBM_TX_SEND || s_d.rx == SBM_RX_ACT) begin
      s_d.sclk = !(s_d.phase >= SBM_S3 && s_d.phase <= SBM_S5);
    end else begin
      s_d.sclk = 1'b1;
    end
    s_d.dout  = (s_d.tx == SBM_TX_SEND) ? s_d.tsr[0] : 1'b1;
    s_d.doe_n = (s_d.tx != SBM_TX_SEND);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.ctrl  <= SBM_CTRL_RST;
      s_q.pwr   <= SBM_PWR_RST;
      s_q.timer_mode_reg  <= SBM_TIMER_MODE_REG_RST;
      s_q.tx    <= SBM_TX_IDLE;
      s_q.rx    <= SBM_RX_IDLE;
      s_q.sclk  <= 1'b1;
      s_q.dout  <= 1'b1;
      s_q.doe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign apb_pready          = 1'b1;
  assign apb_pslverr         = s_q.pslverr;
  assign apb_prdata          = s_q.prdata;
  assign shift_data_pin_out  = s_q.dout;
  assign shift_data_pin_oe_n = s_q.doe_n;
  assign shift_clock_pin     = s_q.sclk;
  assign baud_bit_tick       = s_q.bit_tick;
  assign baud_sample_tick    = s_q.samp_tick;
  assign serial_mode         = {s_q.ctrl[SBM_CTRL_MODE_HI], s_q.ctrl[SBM_CTRL_MODE_LO]};

endmodule : sbm_top

// ---- rtl/sbm_pkg.sv ----
// Purpose: constants and types for the serial baud and shift-mode block
// Assumes: one cpu clock per machine state, six states per machine cycle
// Notes: register map is one aligned 32-bit word per register
package sbm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] SBM_OFS_CTRL   = 8'h00;
  localparam logic [7:0] SBM_OFS_BUF    = 8'h04;
  localparam logic [7:0] SBM_OFS_PWR    = 8'h08;
  localparam logic [7:0] SBM_OFS_TIMER_MODE_REG   = 8'h0c;
  localparam logic [7:0] SBM_OFS_RELOAD = 8'h10;
  localparam logic [7:0] SBM_OFS_STATUS = 8'h14;

  // serial control bit positions
  localparam int SBM_CTRL_MODE_HI = 7;
  localparam int SBM_CTRL_MODE_LO = 6;
  localparam int SBM_CTRL_REN     = 4;
  localparam int SBM_CTRL_TI      = 1;
  localparam int SBM_CTRL_RI      = 0;
  // power control: baud double bit
  localparam int SBM_PWR_DBL      = 7;
  // timer mode upper nibble fields
  localparam int SBM_TIMER_MODE_REG_CT      = 6;
  localparam int SBM_TIMER_MODE_REG_M1      = 5;
  localparam int SBM_TIMER_MODE_REG_M0      = 4;

  localparam logic [7:0] SBM_CTRL_RST = 8'h00;
  localparam logic [7:0] SBM_PWR_RST  = 8'h00;
  localparam logic [7:0] SBM_TIMER_MODE_REG_RST = 8'h00;

  // machine cycle: states s1..s6 coded 0..5
  localparam logic [2:0] SBM_S1 = 3'h0;
  localparam logic [2:0] SBM_S3 = 3'h2;
  localparam logic [2:0] SBM_S5 = 3'h4;
  localparam logic [2:0] SBM_S6 = 3'h5;

  localparam logic [8:0] SBM_TX_MARK   = 9'h100;
  localparam logic [7:0] SBM_TX_LAST   = 8'h01;
  localparam logic [7:0] SBM_RX_INIT   = 8'hfe;
  localparam logic [4:0] SBM_BD_LAST32 = 5'h1f;
  localparam logic [3:0] SBM_BD_LAST16 = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    SBM_SMODE_SHIFT = 2'b00,
    SBM_SMODE_ASY8  = 2'b01,
    SBM_SMODE_FIX9  = 2'b10,
    SBM_SMODE_VAR9  = 2'b11
  } sbm_smode_e;

  typedef enum logic [1:0] {
    SBM_TX_IDLE = 2'b00,
    SBM_TX_PEND = 2'b01,
    SBM_TX_ARM  = 2'b10,
    SBM_TX_SEND = 2'b11
  } sbm_tx_e;

  typedef enum logic [1:0] {
    SBM_RX_IDLE = 2'b00,
    SBM_RX_ARM  = 2'b01,
    SBM_RX_ACT  = 2'b10
  } sbm_rx_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sbm_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sbm_apb_rsp_s;

  typedef struct packed {
    logic [2:0]  phase;
    logic [7:0]  ctrl;
    logic [7:0]  pwr;
    logic [7:0]  timer_mode_reg;
    logic [7:0]  th;
    logic [7:0]  tl;
    logic [7:0]  rx_buf;
    logic [8:0]  tsr;
    logic [7:0]  rsr;
    logic        samp;
    sbm_tx_e     tx;
    sbm_rx_e     rx;
    logic [4:0]  bd;
    logic        bit_tick;
    logic        samp_tick;
    logic [1:0]  t1_sync;
    logic        t1_prev;
    logic [1:0]  din_sync;
    logic [31:0] prdata;
    logic        pslverr;
    logic        sclk;
    logic        dout;
    logic        doe_n;
  } sbm_state_s;

endpackage : sbm_pkg

// ---- test/sbm_assertions.sv ----
// Purpose: port checks of sbm_top
// Assumes: baud double and mode writes are tracked from apb
// Notes: the first tick gap after any write is not judged
`timescale 1ns/1ps
module sbm_assertions (
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire sbm_pkg::sbm_apb_req_s apb_req,
  input wire logic                  shift_data_pin_out,
  input wire logic                  shift_data_pin_oe_n,
  input wire logic                  shift_clock_pin,
  input wire logic                  baud_bit_tick,
  input wire logic [1:0]            serial_mode
);
  import sbm_pkg::*;
  logic [7:0] low_q;
  logic [4:0] gap_q;
  logic [1:0] wmode_q;
  logic       dbl_q;
  logic       seen_q;
  logic       wctl_q;
  logic       wr;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_q   <= 8'h00;
      gap_q   <= 5'h00;
      wmode_q <= 2'b00;
      dbl_q   <= 1'b0;
      seen_q  <= 1'b0;
      wctl_q  <= 1'b0;
    end else begin
      low_q  <= shift_data_pin_oe_n ? 8'h00 : low_q + 8'h01;
      gap_q  <= baud_bit_tick ? 5'h00 : gap_q + 5'h01;
      // a write may change the rate, so the gap ending next is partial
      seen_q <= !wr && (seen_q || baud_bit_tick);
      wctl_q <= wr && apb_req.paddr == SBM_OFS_CTRL;
      if (wr && apb_req.paddr == SBM_OFS_CTRL) wmode_q <= apb_req.pwdata[7:6];
      if (wr && apb_req.paddr == SBM_OFS_PWR) dbl_q <= apb_req.pwdata[SBM_PWR_DBL];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_clk_shape: assert property (
    $fell(shift_clock_pin) |-> !shift_clock_pin [*3] ##1 shift_clock_pin [*3])
    else $error("shift clock not three low then three high");
  a_send_len: assert property ($rose(shift_data_pin_oe_n) |-> low_q == 8'h30)
    else $error("send not eight machine cycles");
  a_send_start: assert property (
    $fell(shift_data_pin_oe_n) |-> shift_clock_pin ##1 shift_clock_pin ##1 !shift_clock_pin)
    else $error("send did not start at state one");
  a_bit_edge: assert property (
    !shift_data_pin_oe_n && $changed(shift_data_pin_out) |->
      $past(shift_clock_pin) && shift_clock_pin ##1 shift_clock_pin ##1 !shift_clock_pin)
    else $error("data bit changed off the cycle boundary");
  a_drive_mode0: assert property (!shift_data_pin_oe_n |-> serial_mode == SBM_SMODE_SHIFT)
    else $error("data pin driven outside mode 0");
  a_mode_follow: assert property (wctl_q |-> ##[0:1] serial_mode == wmode_q)
    else $error("mode output not following control");
  a_mode2_gap: assert property (
    baud_bit_tick && seen_q && serial_mode == SBM_SMODE_FIX9 |-> gap_q == (dbl_q ? 5'h0f : 5'h1f))
    else $error("mode 2 bit tick spacing wrong");
  a_quiet_mode0: assert property (
    serial_mode == 2'b00 && $past(serial_mode) == 2'b00 && $past(serial_mode, 2) == 2'b00
      |-> !baud_bit_tick)
    else $error("bit tick in mode 0");
endmodule : sbm_assertions

bind sbm_top sbm_assertions chk_u (.sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req),
  .shift_data_pin_out(shift_data_pin_out), .shift_data_pin_oe_n(shift_data_pin_oe_n),
  .shift_clock_pin(shift_clock_pin), .baud_bit_tick(baud_bit_tick), .serial_mode(serial_mode));

// ---- test/sbm_shift_partner.sv ----
// Purpose: external shift register on the mode 0 pins
// Assumes: data line has a pull-up, so an idle partner leaves it at 1
// Notes: captures on rising shift clock, presents on falling shift clock
`timescale 1ns/1ps
module sbm_shift_partner (
  input  wire logic       shift_clock_pin,
  input  wire logic       line_level,
  input  wire logic       dev_oe_n,
  input  wire logic       arm,
  input  wire logic [7:0] send_byte,
  output logic            part_drive,
  output logic [7:0]      got_byte,
  output logic [3:0]      got_cnt
);
  logic [3:0] idx;
  initial got_byte = 8'h00;
  initial got_cnt = 4'h0;
  // until armed the partner lets the line rest at its pull-up level
  initial idx = 4'h0;
  initial part_drive = 1'b1;
  always @(posedge shift_clock_pin) begin
    if (!dev_oe_n) begin
      got_byte <= {line_level, got_byte[7:1]};
      got_cnt  <= got_cnt + 4'h1;
    end
  end
  // new bit at the fall leaves two states of setup before the device samples
  always @(negedge shift_clock_pin or negedge arm) begin
    if (!arm) begin
      idx        <= 4'h0;
      part_drive <= 1'b1;
    end else if (dev_oe_n) begin
      part_drive <= idx < 4'h8 ? send_byte[idx[2:0]] : 1'b1;
      idx        <= idx + 4'h1;
    end
  end
endmodule : sbm_shift_partner

// ---- test/sbm_top_test.sv ----
// Purpose: self-checking bench for sbm_top
// Assumes: apb answer comes whenever pready is seen, waits cut by watchdog
// Notes: tick gaps are judged after two settling ticks
`timescale 1ns/1ps
module sbm_top_test;
  import sbm_pkg::*;
  logic         sys_clk = 1'b0;
  logic         nrst = 1'b0;
  sbm_apb_req_s req = '0;
  logic         pready, perr, re, dout, oe_n, sclk, btk, stk, pdrv;
  logic         cnt_pin = 1'b0, arm = 1'b0, tsel = 1'b0;
  logic [31:0]  prdata, rd;
  logic [1:0]   smode;
  logic [7:0]   gbyte;
  logic [3:0]   gcnt, c0;
  logic [2:0]   div_q = 3'h0;
  int           n_fail = 0, cmp_count = 0, n;
  wire          line = oe_n ? pdrv : dout;
  wire          tk = tsel ? stk : btk;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    div_q   <= div_q + 3'h1;
    cnt_pin <= div_q[2];
  end
  sbm_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .apb_req(req), .apb_pready(pready),
    .apb_pslverr(perr), .apb_prdata(prdata), .timer_count_pin(cnt_pin), .shift_data_pin_in(line),
    .shift_data_pin_out(dout), .shift_data_pin_oe_n(oe_n), .shift_clock_pin(sclk),
    .baud_bit_tick(btk), .baud_sample_tick(stk), .serial_mode(smode));
  sbm_shift_partner part_u (.shift_clock_pin(sclk), .line_level(line), .dev_oe_n(oe_n),
    .arm(arm), .send_byte(8'hc5), .part_drive(pdrv), .got_byte(gbyte), .got_cnt(gcnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    re = perr;
    req <= '0;
  endtask : apb
  task automatic gap(input logic s, input logic [31:0] exp);
    tsel = s;
    repeat (2) @(posedge sys_clk iff tk === 1'b1);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (tk !== 1'b1);
    chk(n, exp);
  endtask : gap
  task automatic wait_oe(input logic v);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (oe_n !== v && n < 200);
  endtask : wait_oe
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_regs;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
      chk(re, i == 6);
    end
  endtask : s_regs
  task automatic s_modes;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, SBM_OFS_CTRL, 32'(m) << 6);
      apb(1'b0, SBM_OFS_STATUS, 32'h0);
      chk(rd[1:0], m);
      chk(smode, m);
    end
  endtask : s_modes
  task automatic s_tx;
    apb(1'b1, SBM_OFS_CTRL, 32'h0);
    c0 = gcnt;
    apb(1'b1, SBM_OFS_BUF, 32'h96);
    wait_oe(1'b0);
    chk(n inside {[8:13]}, 1'b1);
    wait_oe(1'b1);
    chk(oe_n, 1'b1);
    chk(gbyte, 8'h96);
    chk(4'(gcnt - c0), 4'h8);
    apb(1'b0, SBM_OFS_CTRL, 32'h0);
    chk(rd[SBM_CTRL_TI], 1'b1);
    apb(1'b1, SBM_OFS_CTRL, 32'h0);
    apb(1'b0, SBM_OFS_CTRL, 32'h0);
    chk(rd[SBM_CTRL_TI], 1'b0);
  endtask : s_tx
  task automatic s_rx;
    arm <= 1'b1;
    c0 = gcnt;
    apb(1'b1, SBM_OFS_CTRL, 32'h10);
    n = 0;
    do begin apb(1'b0, SBM_OFS_CTRL, 32'h0); n++; end while (rd[0] !== 1'b1 && n < 40);
    chk(rd[SBM_CTRL_RI], 1'b1);
    chk(gcnt, c0);
    apb(1'b0, SBM_OFS_BUF, 32'h0);
    chk(rd, 32'hc5);
    apb(1'b1, SBM_OFS_CTRL, 32'h0);
    arm <= 1'b0;
  endtask : s_rx
  task automatic s_baud;
    apb(1'b1, SBM_OFS_CTRL, 32'h80);
    gap(1'b0, 32);
    gap(1'b1, 2);
    apb(1'b1, SBM_OFS_PWR, 32'h80);
    gap(1'b0, 16);
    apb(1'b1, SBM_OFS_TIMER_MODE_REG, 32'h20); // timer 1 auto-reload, counting machine cycles
    apb(1'b1, SBM_OFS_RELOAD, 32'hfe);
    apb(1'b1, SBM_OFS_CTRL, 32'h40);
    gap(1'b0, 192);
    apb(1'b1, SBM_OFS_PWR, 32'h0);
    gap(1'b0, 384);
    gap(1'b1, 24);
    apb(1'b1, SBM_OFS_TIMER_MODE_REG, 32'h60);
    apb(1'b1, SBM_OFS_RELOAD, 32'hff);
    gap(1'b0, 256);
    apb(1'b1, SBM_OFS_CTRL, 32'hc0);
    gap(1'b0, 256);
  endtask : s_baud
  task automatic s_tmodes;
    apb(1'b1, SBM_OFS_PWR, 32'h80);
    tsel = 1'b1;
    for (int t = 0; t < 2; t++) begin
      // 13-bit then 16-bit timer; high byte at ff brings the overflow in reach
      apb(1'b1, SBM_OFS_TIMER_MODE_REG, 32'(t) << SBM_TIMER_MODE_REG_M0);
      apb(1'b1, SBM_OFS_RELOAD, 32'hff);
      n = 0;
      do begin @(posedge sys_clk); n++; end while (tk !== 1'b1 && n < 2000);
      chk(n < 1600, 1'b1);
    end
  endtask : s_tmodes
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    s_regs;
    s_modes;
    s_tx;
    s_rx;
    s_baud;
    s_tmodes;
    end_sim;
  end
  initial begin
    #500000;
    n_fail++;
    end_sim;
  end
endmodule : sbm_top_test
